// ---- hdl/dpllr_pkg.sv ----
// Purpose: shared constants and types for the loop control/status bank
// Assumes: byte-wide register port, 40 MHz system clock
// Notes:   offsets are byte addresses, wide registers are little endian
package dpllr_pkg;
   // register byte offsets (first byte of each register)
   localparam logic [7:0] A_FB_INT  = 8'h00; // 2 bytes
   localparam logic [7:0] A_FB_CORR = 8'h02; // 2 bytes
   localparam logic [7:0] A_PHASE   = 8'h04; // 4 bytes
   localparam logic [7:0] A_FREQ    = 8'h08; // 4 bytes
   localparam logic [7:0] A_LOCK    = 8'h0c; // 4 bytes
   localparam logic [7:0] A_TDC     = 8'h10;
   localparam logic [7:0] A_STS     = 8'h11;
   localparam logic [7:0] A_EVT     = 8'h12;
   localparam logic [7:0] A_LOLCNT  = 8'h13;
   localparam logic [7:0] A_LOLTHR  = 8'h14;
   localparam logic [7:0] A_NUM     = 8'h18; // 6 bytes
   localparam logic [7:0] A_DEN     = 8'h20; // 6 bytes
   // byte counts and index of the byte that commits
   localparam logic [3:0] N_2B = 4'h2;
   localparam logic [3:0] N_4B = 4'h4;
   localparam logic [3:0] N_6B = 4'h6;
   localparam logic [2:0] TOP_4B = 3'h3;
   localparam logic [2:0] TOP_6B = 3'h5;
   // values after reset
   localparam logic [13:0] RST_FB_INT  = 14'h0190;
   localparam logic [47:0] RST_DEN     = 48'h0000_0080_0000;
   localparam logic [15:0] RST_TIMER   = 16'h00ff;
   localparam logic [15:0] RST_THRESH  = 16'h0155;
   localparam logic [7:0]  RST_TDC     = 8'h1f;
   // field positions inside the correction register
   localparam int FINE_REV_BIT = 9;
   localparam int PEC_DLY_LSB  = 7;
   localparam logic [1:0] PEC_DLY_ONE = 2'h1;
   // event flag positions
   localparam int EV_STATE = 3;
   localparam int EV_HOLD  = 2;
   localparam int EV_LMT   = 1;
   localparam int EV_UNLK  = 0;
   localparam logic [3:0] LOL_MAX = 4'hf;
   // lock timer counts in half milliseconds
   localparam longint CLK_PERIOD_PS = 25000;
   localparam longint HALF_MS_PS    = 500000000;
   localparam int HALF_MS_CYCLES = int'(HALF_MS_PS / CLK_PERIOD_PS);
   // operating modes from the mode register
   localparam logic [1:0] MODE_FREERUN = 2'h0;
   localparam logic [1:0] MODE_AUTO    = 2'h1;
   localparam logic [1:0] MODE_HOLD    = 2'h2;
   // loop states and their status codes
   typedef enum logic [2:0] {
      ST_FREERUN, ST_NORMAL, ST_HOLDOVER, ST_WRFREQ, ST_ACQUIRE, ST_HITLESS
   } dpllr_state_t;
   localparam logic [2:0] STS_FREERUN  = 3'h0;
   localparam logic [2:0] STS_NORMAL   = 3'h1;
   localparam logic [2:0] STS_HOLDOVER = 3'h2;
   localparam logic [2:0] STS_WRFREQ   = 3'h3;
   localparam logic [2:0] STS_ACQUIRE  = 3'h4;
   localparam logic [2:0] STS_HITLESS  = 3'h5;
endpackage

// ---- hdl/dpllr_lock_qual.sv ----
// Purpose: measures how long the phase error stays under threshold
// Assumes: i_run drops as soon as the error rises above threshold
// Notes:   pulses o_met each time i_half_ms half-ms ticks elapse
`timescale 1ns/1ps
module dpllr_lock_qual #(
   parameter int HALF_MS_CYCLES = dpllr_pkg::HALF_MS_CYCLES
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_run,     // error below threshold
   input  wire logic        i_restart, // state changed
   input  wire logic [15:0] i_half_ms, // interval length, in half ms
   output logic             o_met
);
   logic [31:0] div_reg;  // cycles within the current half ms
   logic [15:0] half_reg; // half-ms ticks accumulated
   logic        tick;

   assign tick = (div_reg == 32'(HALF_MS_CYCLES - 1));

   // half-ms divider, held at zero while not qualifying
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_run || i_restart || o_met) begin
         div_reg <= 32'h0;
      end else if (tick) begin
         div_reg <= 32'h0;
      end else begin
         div_reg <= div_reg + 32'h1;
      end
   end

   // tick accumulator; any excursion starts the wait over
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_run || i_restart || o_met) begin
         half_reg <= 16'h0;
      end else if (tick) begin
         half_reg <= half_reg + 16'h1;
      end
   end

   // one-cycle pulse; a zero timer qualifies at once
   always_ff @(posedge i_clk) begin
      if (i_rst || i_restart) begin
         o_met <= 1'b0;
      end else begin
         o_met <= i_run && !o_met && (half_reg >= i_half_ms);
      end
   end
endmodule

// ---- hdl/dpllr_regs.sv ----
// Purpose: control and status registers of the digital loop
// Assumes: one byte access per cycle on the register port
// Notes:   phase, frequency and divider group apply on a top byte or on an integer byte that changes the divider; phase offset zeroed while i_hitless_en is set
`timescale 1ns/1ps
module dpllr_regs #(
   parameter int HALF_MS_CYCLES = dpllr_pkg::HALF_MS_CYCLES
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_wr_en,      // byte write strobe
   input  wire logic        i_rd_en,      // byte read strobe
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wr_data,
   output logic      [7:0]  o_rd_data,
   input  wire logic        i_loop_soft_reset,
   input  wire logic        i_clk_gated,
   input  wire logic [1:0]  i_mode,
   input  wire logic        i_ref_ok,     // selected reference qualified
   input  wire logic        i_ref_sel,    // 0 ref_input_a, 1 ref_input_b
   input  wire logic        i_hitless_en,
   input  wire logic        i_hitless_done,
   input  wire logic        i_filter_profile_switch_en,
   input  wire logic [23:0] i_phase_err,  // signed, 8 TDC steps per lsb
   input  wire logic [30:0] i_fine_ts,    // analog fine timestamp
   input  wire logic [15:0] i_sdm_rem,    // feedback sdm remainder
   output logic [13:0]      o_feedback_int_divisor,
   output logic [47:0]      o_feedback_fraction_numerator,
   output logic [47:0]      o_feedback_fraction_denominator,
   output logic             o_fb_apply,
   output logic [30:0]      o_fine_ts,
   output logic [22:0]      o_sdm_corr,
   output logic [29:0]      o_phase_offset,
   output logic             o_phase_apply,
   output logic [28:0]      o_freq_word,
   output logic             o_freq_apply,
   output logic [7:0]       o_tdc_delay,
   output logic             o_use_acquire_profile,
   output logic [2:0]       o_state,
   output logic             o_lock
);
   // byte address falls inside a register of n bytes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b,
                                input logic [3:0] n);
      return (a >= b) && (a < b + {4'h0, n});
   endfunction

   // byte index within a wide register
   function automatic logic [2:0] idx(input logic [7:0] a,
                                      input logic [7:0] b);
      logic [7:0] d;
      d = a - b;
      return d[2:0];
   endfunction

   // replace one byte of a wide value
   function automatic logic [63:0] put(input logic [63:0] v,
                                       input logic [2:0] i,
                                       input logic [7:0] d);
      logic [63:0] r;
      r = v;
      r[{i, 3'h0} +: 8] = d;
      return r;
   endfunction

   // pick one byte of a wide value
   function automatic logic [7:0] get(input logic [63:0] v,
                                      input logic [2:0] i);
      return v[{i, 3'h0} +: 8];
   endfunction

   // magnitude of the signed phase error, saturated to 16 bits
   function automatic logic [15:0] mag(input logic [23:0] e);
      logic [23:0] m;
      m = e[23] ? (~e + 24'h1) : e;
      return (|m[23:16]) ? 16'hffff : m[15:0];
   endfunction

   // software-visible storage
   logic [13:0] fb_int_reg;
   logic [9:0]  corr_reg;       // fine_rev, delay code, multiplier
   logic [29:0] phase_pend_reg; // pending until top byte lands
   logic [28:0] freq_pend_reg;
   logic [15:0] timer_reg;
   logic [15:0] thresh_reg;
   logic [47:0] num_reg;
   logic [47:0] den_reg;
   logic [3:0]  lol_thr_reg;
   logic [3:0]  lol_cnt_reg;
   logic [3:0]  evt_reg;
   logic [29:0] phase_app_reg;  // last committed offset
   logic [15:0] sdm_d1_reg;     // remainder one cycle late
   logic        ref_sel_reg;

   // loop state
   dpllr_pkg::dpllr_state_t state_reg, state_next;
   logic        lock_next;
   logic        below;
   logic        qual_met;
   logic        st_change;

   // decoded writes and the values they would leave
   logic        w_fbi, w_cor, w_ph, w_fr, w_lk, w_num, w_den;
   logic [63:0] fbi_v, cor_v, ph_v, fr_v, lk_v, num_v, den_v;

   always_comb begin
      w_fbi = i_wr_en && hit(i_addr, dpllr_pkg::A_FB_INT, dpllr_pkg::N_2B);
      w_cor = i_wr_en && hit(i_addr, dpllr_pkg::A_FB_CORR, dpllr_pkg::N_2B);
      w_ph  = i_wr_en && hit(i_addr, dpllr_pkg::A_PHASE, dpllr_pkg::N_4B);
      w_fr  = i_wr_en && hit(i_addr, dpllr_pkg::A_FREQ, dpllr_pkg::N_4B);
      w_lk  = i_wr_en && hit(i_addr, dpllr_pkg::A_LOCK, dpllr_pkg::N_4B);
      w_num = i_wr_en && hit(i_addr, dpllr_pkg::A_NUM, dpllr_pkg::N_6B);
      w_den = i_wr_en && hit(i_addr, dpllr_pkg::A_DEN, dpllr_pkg::N_6B);
      fbi_v = put({50'h0, fb_int_reg}, idx(i_addr, dpllr_pkg::A_FB_INT),
                  i_wr_data);
      cor_v = put({54'h0, corr_reg}, idx(i_addr, dpllr_pkg::A_FB_CORR),
                  i_wr_data);
      ph_v  = put({34'h0, phase_pend_reg}, idx(i_addr, dpllr_pkg::A_PHASE),
                  i_wr_data);
      fr_v  = put({35'h0, freq_pend_reg}, idx(i_addr, dpllr_pkg::A_FREQ),
                  i_wr_data);
      lk_v  = put({32'h0, timer_reg, thresh_reg},
                  idx(i_addr, dpllr_pkg::A_LOCK), i_wr_data);
      num_v = put({16'h0, num_reg}, idx(i_addr, dpllr_pkg::A_NUM),
                  i_wr_data);
      den_v = put({16'h0, den_reg}, idx(i_addr, dpllr_pkg::A_DEN),
                  i_wr_data);
   end

   // plain configuration storage; reserved bits are never stored
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fb_int_reg     <= dpllr_pkg::RST_FB_INT;
         corr_reg       <= 10'h0;
         phase_pend_reg <= 30'h0;
         freq_pend_reg  <= 29'h0;
         timer_reg      <= dpllr_pkg::RST_TIMER;
         thresh_reg     <= dpllr_pkg::RST_THRESH;
         num_reg        <= 48'h0;
         den_reg        <= dpllr_pkg::RST_DEN;
         lol_thr_reg    <= 4'h0;
         o_tdc_delay    <= dpllr_pkg::RST_TDC;
      end else begin
         if (w_fbi) fb_int_reg <= fbi_v[13:0];
         if (w_cor) corr_reg <= cor_v[9:0];
         if (w_ph) phase_pend_reg <= ph_v[29:0];
         if (w_fr) freq_pend_reg <= fr_v[28:0];
         if (w_lk) begin
            timer_reg  <= lk_v[31:16];
            thresh_reg <= lk_v[15:0];
         end
         if (w_num) num_reg <= num_v[47:0];
         if (w_den) den_reg <= den_v[47:0];
         if (i_wr_en && i_addr == dpllr_pkg::A_LOLTHR) begin
            lol_thr_reg <= i_wr_data[3:0];
         end
         if (i_wr_en && i_addr == dpllr_pkg::A_TDC) begin
            o_tdc_delay <= i_wr_data;
         end
      end
   end

   // feedback divider group: all three fields move together
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_feedback_int_divisor          <= dpllr_pkg::RST_FB_INT;
         o_feedback_fraction_numerator   <= 48'h0;
         o_feedback_fraction_denominator <= dpllr_pkg::RST_DEN;
         o_fb_apply                      <= 1'b0;
      end else begin
         o_fb_apply <= 1'b0;
         // an unchanged integer rewrite is not a commit
         if ((w_fbi && fbi_v[13:0] != fb_int_reg)
             || (w_num && idx(i_addr, dpllr_pkg::A_NUM)
                 == dpllr_pkg::TOP_6B)
             || (w_den && idx(i_addr, dpllr_pkg::A_DEN)
                 == dpllr_pkg::TOP_6B)) begin
            o_feedback_int_divisor <= w_fbi ? fbi_v[13:0] : fb_int_reg;
            o_feedback_fraction_numerator <= w_num ? num_v[47:0] : num_reg;
            o_feedback_fraction_denominator <=
               w_den ? den_v[47:0] : den_reg;
            o_fb_apply <= 1'b1;
         end
      end
   end

   // phase offset and frequency word commit on their top byte
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         phase_app_reg  <= 30'h0;
         o_phase_offset <= 30'h0;
         o_phase_apply  <= 1'b0;
         o_freq_word    <= 29'h0;
         o_freq_apply   <= 1'b0;
      end else begin
         o_phase_apply <= 1'b0;
         o_freq_apply  <= 1'b0;
         if (w_ph && idx(i_addr, dpllr_pkg::A_PHASE)
             == dpllr_pkg::TOP_4B) begin
            phase_app_reg <= ph_v[29:0];
            o_phase_apply <= 1'b1;
         end
         // hitless switching measures its own offset instead
         o_phase_offset <= i_hitless_en ? 30'h0 : phase_app_reg;
         if (w_fr && idx(i_addr, dpllr_pkg::A_FREQ)
             == dpllr_pkg::TOP_4B) begin
            o_freq_word  <= fr_v[28:0];
            o_freq_apply <= 1'b1;
         end
      end
   end

   // datapath helpers: timestamp order and error correction
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_fine_ts  <= 31'h0;
         sdm_d1_reg <= 16'h0;
         o_sdm_corr <= 23'h0;
      end else begin
         // reversal is debug only; it costs nothing when clear
         for (int b = 0; b < 31; b++) begin
            o_fine_ts[b] <= corr_reg[dpllr_pkg::FINE_REV_BIT] ?
                            i_fine_ts[30 - b] : i_fine_ts[b];
         end
         sdm_d1_reg <= i_sdm_rem;
         // only code one delays; the other three pass straight
         o_sdm_corr <= ((corr_reg[dpllr_pkg::PEC_DLY_LSB +: 2]
                         == dpllr_pkg::PEC_DLY_ONE) ?
                        sdm_d1_reg : i_sdm_rem)
                       * corr_reg[6:0];
      end
   end

   // lock qualification: error magnitude under the threshold
   assign below = mag(i_phase_err) < thresh_reg;

   dpllr_lock_qual #(
      .HALF_MS_CYCLES(HALF_MS_CYCLES)
   ) u_qual (
      .i_clk     (i_clk),
      .i_rst     (i_rst || i_loop_soft_reset),
      .i_run     (below && (state_reg == dpllr_pkg::ST_ACQUIRE
                  || (state_reg == dpllr_pkg::ST_NORMAL && !o_lock))),
      .i_restart (st_change),
      .i_half_ms (timer_reg),
      .o_met     (qual_met)
   );

   // loop state sequencing
   always_comb begin
      state_next = state_reg;
      lock_next  = o_lock;
      if (i_mode == dpllr_pkg::MODE_FREERUN) begin
         state_next = dpllr_pkg::ST_FREERUN;
      end else if (i_mode == dpllr_pkg::MODE_HOLD) begin
         state_next = dpllr_pkg::ST_HOLDOVER;
      end else if (i_mode != dpllr_pkg::MODE_AUTO) begin
         state_next = dpllr_pkg::ST_WRFREQ;
      end else begin
         unique case (state_reg)
            dpllr_pkg::ST_FREERUN, dpllr_pkg::ST_HOLDOVER,
            dpllr_pkg::ST_WRFREQ: begin
               if (i_ref_ok) state_next = dpllr_pkg::ST_ACQUIRE;
            end
            dpllr_pkg::ST_ACQUIRE: begin
               if (!i_ref_ok) state_next = dpllr_pkg::ST_FREERUN;
               else if (qual_met) state_next = dpllr_pkg::ST_NORMAL;
            end
            dpllr_pkg::ST_NORMAL: begin
               if (!i_ref_ok) begin
                  state_next = dpllr_pkg::ST_HOLDOVER;
               end else if (!below && !o_lock) begin
                  state_next = dpllr_pkg::ST_ACQUIRE;
               end else if (i_hitless_en && i_ref_sel != ref_sel_reg) begin
                  state_next = dpllr_pkg::ST_HITLESS;
               end else if (qual_met) begin
                  lock_next = 1'b1;
               end
            end
            dpllr_pkg::ST_HITLESS: begin
               if (!i_ref_ok) state_next = dpllr_pkg::ST_HOLDOVER;
               else if (i_hitless_done) state_next = dpllr_pkg::ST_NORMAL;
            end
         endcase
      end
      // lock survives only inside normal and hitless switching
      if (state_next != dpllr_pkg::ST_NORMAL
          && state_next != dpllr_pkg::ST_HITLESS) begin
         lock_next = 1'b0;
      end
   end

   assign st_change = (state_next != state_reg);

   // state, lock and reported fields; soft reset parks the loop
   always_ff @(posedge i_clk) begin
      if (i_rst || i_loop_soft_reset) begin
         state_reg             <= dpllr_pkg::ST_FREERUN;
         o_lock                <= 1'b0;
         ref_sel_reg           <= 1'b0;
         o_state               <= dpllr_pkg::STS_FREERUN;
         o_use_acquire_profile <= 1'b0;
      end else begin
         state_reg   <= state_next;
         o_lock      <= lock_next;
         ref_sel_reg <= i_ref_sel;
         unique case (state_next)
            dpllr_pkg::ST_FREERUN:  o_state <= dpllr_pkg::STS_FREERUN;
            dpllr_pkg::ST_NORMAL:   o_state <= dpllr_pkg::STS_NORMAL;
            dpllr_pkg::ST_HOLDOVER: o_state <= dpllr_pkg::STS_HOLDOVER;
            dpllr_pkg::ST_WRFREQ:   o_state <= dpllr_pkg::STS_WRFREQ;
            dpllr_pkg::ST_ACQUIRE:  o_state <= dpllr_pkg::STS_ACQUIRE;
            dpllr_pkg::ST_HITLESS:  o_state <= dpllr_pkg::STS_HITLESS;
         endcase
         // without the switch the normal profile is used throughout
         o_use_acquire_profile <= i_filter_profile_switch_en
            && state_next == dpllr_pkg::ST_ACQUIRE;
      end
   end

   // unlock counter: preset blocked while gated or in soft reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lol_cnt_reg <= 4'h0;
      end else if (i_wr_en && i_addr == dpllr_pkg::A_LOLCNT
                   && !i_clk_gated && !i_loop_soft_reset) begin
         lol_cnt_reg <= i_wr_data[3:0];
      end else if (o_lock && !lock_next
                   && lol_cnt_reg != dpllr_pkg::LOL_MAX) begin
         lol_cnt_reg <= lol_cnt_reg + 4'h1;
      end
   end

   // sticky events; a set in the clearing cycle wins
   always_ff @(posedge i_clk) begin
      logic [3:0] clr;
      logic [3:0] set;
      if (i_rst) begin
         evt_reg <= 4'h0;
      end else begin
         clr = (i_wr_en && i_addr == dpllr_pkg::A_EVT) ?
               i_wr_data[3:0] : 4'h0;
         set = 4'h0;
         set[dpllr_pkg::EV_STATE] = st_change;
         set[dpllr_pkg::EV_HOLD]  = st_change
            && state_next == dpllr_pkg::ST_HOLDOVER;
         set[dpllr_pkg::EV_LMT]   = lol_cnt_reg > lol_thr_reg;
         set[dpllr_pkg::EV_UNLK]  = o_lock && !lock_next;
         evt_reg <= (evt_reg & ~clr) | set;
      end
   end

   // read port: one cycle latency, unmapped bytes read zero
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rd_data <= 8'h0;
      end else if (i_rd_en) begin
         if (hit(i_addr, dpllr_pkg::A_FB_INT, dpllr_pkg::N_2B)) begin
            o_rd_data <= get({50'h0, fb_int_reg},
                             idx(i_addr, dpllr_pkg::A_FB_INT));
         end else if (hit(i_addr, dpllr_pkg::A_FB_CORR, dpllr_pkg::N_2B))
         begin
            o_rd_data <= get({54'h0, corr_reg},
                             idx(i_addr, dpllr_pkg::A_FB_CORR));
         end else if (hit(i_addr, dpllr_pkg::A_PHASE, dpllr_pkg::N_4B)) begin
            o_rd_data <= get({34'h0, phase_pend_reg},
                             idx(i_addr, dpllr_pkg::A_PHASE));
         end else if (hit(i_addr, dpllr_pkg::A_FREQ, dpllr_pkg::N_4B)) begin
            o_rd_data <= get({35'h0, freq_pend_reg},
                             idx(i_addr, dpllr_pkg::A_FREQ));
         end else if (hit(i_addr, dpllr_pkg::A_LOCK, dpllr_pkg::N_4B)) begin
            o_rd_data <= get({32'h0, timer_reg, thresh_reg},
                             idx(i_addr, dpllr_pkg::A_LOCK));
         end else if (hit(i_addr, dpllr_pkg::A_NUM, dpllr_pkg::N_6B)) begin
            o_rd_data <= get({16'h0, num_reg},
                             idx(i_addr, dpllr_pkg::A_NUM));
         end else if (hit(i_addr, dpllr_pkg::A_DEN, dpllr_pkg::N_6B)) begin
            o_rd_data <= get({16'h0, den_reg},
                             idx(i_addr, dpllr_pkg::A_DEN));
         end else if (i_addr == dpllr_pkg::A_TDC) begin
            o_rd_data <= o_tdc_delay;
         end else if (i_addr == dpllr_pkg::A_STS) begin
            o_rd_data <= {1'b0, o_state, 2'b00, ref_sel_reg, o_lock};
         end else if (i_addr == dpllr_pkg::A_EVT) begin
            o_rd_data <= {4'h0, evt_reg};
         end else if (i_addr == dpllr_pkg::A_LOLCNT) begin
            o_rd_data <= {4'h0, lol_cnt_reg};
         end else if (i_addr == dpllr_pkg::A_LOLTHR) begin
            o_rd_data <= {4'h0, lol_thr_reg};
         end else begin
            o_rd_data <= 8'h0;
         end
      end
   end
endmodule

// ---- dv/dpllr_regs_sva.sv ----
// Purpose: port checks for the loop register bank
// Assumes: sync active-high reset, one byte access per cycle
// Notes:   apply pulses trail their commit byte by one cycle
`timescale 1ns/1ps
module dpllr_regs_sva (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_wr_en,
   input wire logic        i_rd_en,
   input wire logic [7:0]  i_addr,
   input wire logic [7:0]  o_rd_data,
   input wire logic        i_loop_soft_reset,
   input wire logic        i_hitless_en,
   input wire logic        i_filter_profile_switch_en,
   input wire logic        o_fb_apply,
   input wire logic [29:0] o_phase_offset,
   input wire logic        o_phase_apply,
   input wire logic        o_freq_apply,
   input wire logic        o_use_acquire_profile,
   input wire logic [2:0]  o_state,
   input wire logic        o_lock
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   phase_commit_a: assert property (
      o_phase_apply |-> $past(i_wr_en && i_addr == 8'h07))
      else $error("phase applied without top byte");
   freq_commit_a: assert property (
      o_freq_apply |-> $past(i_wr_en && i_addr == 8'h0b))
      else $error("frequency applied without top byte");
   group_commit_a: assert property (
      o_fb_apply |-> $past(i_wr_en)) else $error("divider group stray apply");
   hitless_zero_a: assert property (
      i_hitless_en |=> o_phase_offset == 30'h0)
      else $error("phase offset used in hitless");
   unmapped_read_a: assert property (
      i_rd_en && i_addr == 8'hff |=> o_rd_data == 8'h00)
      else $error("unmapped read not zero");
   profile_off_a: assert property (
      !i_filter_profile_switch_en [*2] |-> !o_use_acquire_profile)
      else $error("acquire profile while switch off");
   lock_state_a: assert property (
      o_lock |-> o_state == 3'h1 || o_state == 3'h5)
      else $error("lock outside normal states");
   parked_a: assert property (
      i_loop_soft_reset [*2] |-> o_state == 3'h0 && !o_lock)
      else $error("soft reset did not park loop");
   cover property (o_lock);
   cover property (o_phase_apply);
   cover property (o_freq_apply);
   cover property (o_use_acquire_profile);
endmodule
bind dpllr_regs dpllr_regs_sva i_sva (.i_clk(i_clk), .i_rst(i_rst),
   .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
   .o_rd_data(o_rd_data), .i_loop_soft_reset(i_loop_soft_reset),
   .i_hitless_en(i_hitless_en), .o_fb_apply(o_fb_apply),
   .i_filter_profile_switch_en(i_filter_profile_switch_en),
   .o_phase_offset(o_phase_offset), .o_phase_apply(o_phase_apply),
   .o_freq_apply(o_freq_apply), .o_state(o_state), .o_lock(o_lock),
   .o_use_acquire_profile(o_use_acquire_profile));

// ---- dv/dpllr_regs_tb.sv ----
// Purpose: directed register and loop-status tests
// Assumes: half interval shortened to 4 cycles
// Notes:   reads land one cycle after the strobe
`timescale 1ns/1ps
module dpllr_regs_tb;
   logic clk = 0, rst = 1, we = 0, re = 0, sr = 0, cg = 0, rs = 0, hl = 0;
   logic [7:0] a = 0, d = 0, q;
   logic [1:0] md = 0;
   logic [23:0] pe = 0;
   logic [15:0] rm = 16'h0005;
   logic [47:0] nm;
   logic [7:0] td;
   logic fp = 0, ap;
   logic [30:0] ft = 0, fto;
   logic [2:0] pl, st;
   logic [13:0] fbi;
   logic [29:0] po;
   logic [28:0] fw;
   logic [22:0] sc;
   logic lk, fa, pa, qa;
   int err_total = 0, n_compared = 0, cyc = 0;
   // address and expected byte after reset, unmapped 0xff last
   logic [15:0] dfl [10] = '{16'h0090, 16'h0101, 16'h0c55, 16'h0d01,
      16'h0eff, 16'h101f, 16'h1100, 16'h1200, 16'h1300, 16'hff00};
   always #12.5 clk = ~clk;
   dpllr_regs #(.HALF_MS_CYCLES(4)) i_dpllr_regs (.i_clk(clk), .i_rst(rst),
      .i_wr_en(we), .i_rd_en(re), .i_addr(a), .i_wr_data(d), .o_rd_data(q),
      .i_loop_soft_reset(sr), .i_clk_gated(cg), .i_mode(md), .i_ref_ok(1'b1),
      .i_ref_sel(rs), .i_hitless_en(hl), .i_hitless_done(1'b0),
      .i_filter_profile_switch_en(fp), .i_phase_err(pe), .i_fine_ts(ft),
      .i_sdm_rem(rm), .o_feedback_int_divisor(fbi),
      .o_feedback_fraction_numerator(nm), .o_feedback_fraction_denominator(),
      .o_fb_apply(fa), .o_fine_ts(fto), .o_sdm_corr(sc), .o_phase_offset(po),
      .o_phase_apply(pa), .o_freq_word(fw), .o_freq_apply(qa),
      .o_tdc_delay(td), .o_use_acquire_profile(ap), .o_state(st), .o_lock(lk));
   task automatic chk(input string n, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   // one byte write; pl keeps the apply pulses it caused
   task automatic wr(input logic [7:0] ad, dt);
      we <= 1; a <= ad; d <= dt;
      @(posedge clk) we <= 0;
      #1 pl = {fa, pa, qa};
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] ad, ex, input string n);
      re <= 1; a <= ad;
      @(posedge clk) re <= 0;
      @(posedge clk) chk(n, 32'(q), 32'(ex));
   endtask
   task automatic finish_test;
      if (err_total == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // hang guard, under two hundred cycles are expected
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      foreach (dfl[i]) rd(dfl[i][15:8], dfl[i][7:0], "reset value");
      chk("tdc out", 32'(td), 32'h1f);
      wr(8'h10, 8'h3c); chk("tdc write", 32'(td), 32'h3c);
      wr(8'h01, 8'hff); chk("fb apply", 32'(pl), 32'h4);
      chk("fb int", 32'(fbi), 32'h3f90);
      rd(8'h01, 8'h3f, "fb reserved");
      wr(8'h04, 8'h21); chk("early phase", 32'(pl), 32'h0);
      wr(8'h07, 8'hff); chk("phase apply", 32'(pl), 32'h2);
      wr(8'h08, 8'h5a); wr(8'h0b, 8'hff);
      chk("freq apply", 32'(pl), 32'h1);
      wr(8'h1d, 8'h80); chk("group apply", 32'(pl), 32'h4);
      chk("group num", 32'(nm[47:16]), 32'h80000000);
      wr(8'h02, 8'h03); wr(8'h03, 8'h02); ft <= 31'h1;
      repeat (3) @(posedge clk);
      chk("phase", 32'(po), 32'h3f000021);
      chk("freq", 32'(fw), 32'h1f00005a);
      chk("fine ts", 32'(fto), 32'h40000000);
      chk("sdm corr", 32'(sc), 32'd15);
      // code one: a new remainder shows one cycle later than it would
      wr(8'h02, 8'h83); rm <= 16'h0007; repeat (2) @(posedge clk);
      chk("sdm delay", 32'(sc), 32'd15);
      @(posedge clk) chk("sdm late", 32'(sc), 32'd21);
      rd(8'h0b, 8'h1f, "freq top");
      hl <= 1; repeat (2) @(posedge clk);
      chk("hitless phase", 32'(po), 32'h0);
      hl <= 0; wr(8'h0e, 8'h02); wr(8'h0f, 8'h00); rs <= 1; md <= 1;
      // error above threshold keeps the loop in acquire
      fp <= 1; pe <= 24'hfffc00; repeat (20) @(posedge clk);
      rd(8'h11, 8'h42, "acquire held");
      chk("acq profile", 32'(ap), 32'h1);
      pe <= 24'h0;
      for (int k = 0; k < 200 && lk !== 1'b1; k++) @(posedge clk);
      chk("lock", 32'(lk), 32'h1);
      chk("nrm profile", 32'(ap), 32'h0);
      rd(8'h11, 8'h13, "status");
      // forcing freerun drops lock, which counts as an unlock
      md <= 0; repeat (4) @(posedge clk);
      rd(8'h12, 8'h0b, "events");
      rd(8'h13, 8'h01, "unlock count");
      wr(8'h12, 8'hff); rd(8'h12, 8'h02, "cleared");
      md <= 2; repeat (4) @(posedge clk);
      rd(8'h12, 8'h0e, "holdover");
      rd(8'h11, 8'h22, "holdover state");
      sr <= 1; wr(8'h13, 8'h00); sr <= 0; cg <= 1; wr(8'h13, 8'h00);
      rd(8'h13, 8'h01, "count kept");
      cg <= 0; wr(8'h13, 8'h00); rd(8'h13, 8'h00, "count clear");
      finish_test();
   end
endmodule
